// >>> sim/lct_cells_tb.sv
// self-checking bench for the combination cell block
`timescale 1ns/1ps
module lct_cells_tb;
    import lct_pkg::*;
    logic                                pclk;        // 50 mhz bus clock
    logic                                presetn;     // active-low reset
    lct_apb_req_t                        apb_req;     // bus request
    lct_apb_rsp_t                        apb_rsp;     // bus answer
    logic [NUM_CELLS-1:0][CELL_IN_W-1:0] matrix_in;   // from the matrix model
    logic [NUM_CELLS-1:0]                matrix_out;  // cell outputs
    logic [NUM_CELLS-1:0][CELL_IN_W-1:0] mv;          // levels handed to the model
    logic [31:0]                         rd;          // last read data
    logic                                er;          // last error flag
    int                                  miscompares; // mismatches seen
    int                                  check_count; // compares made
    // gate truth fields, msb first: and nand or nor xor xnor
    logic [5:0][3:0] gates = {4'b1000, 4'b0111, 4'b1110, 4'b0001, 4'b0110, 4'b1001};
    // three-input truth fields for cells 3 to 8, index 0 is cell 3
    logic [5:0][7:0] t3 = {8'h80, 8'h3c, 8'h96, 8'he8, 8'h7f, 8'h01};
    logic [4:0]      pat = 5'b01011; // five-bit pattern, bit 0 first

    // free-running clock
    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    lct_cells i_lct_cells (
        .pclk       (pclk),
        .presetn    (presetn),
        .apb_req    (apb_req),
        .apb_rsp    (apb_rsp),
        .matrix_in  (matrix_in),
        .matrix_out (matrix_out)
    );

    lct_matrix_model i_lct_matrix_model (
        .pclk      (pclk),
        .matrix_in (matrix_in)
    );

    // verdict and end of run, also reached by a timeout
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    // compare seen against expected and report a difference
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; the request stands until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: 4'hf};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge pclk);
            if (apb_rsp.pready === 1'b1)
                break;
        end
        if (n == 16)
        begin
            miscompares++;
            test_done();
        end
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : xfer

    // new levels, then wait out the two sync stages and the output flop
    task automatic put(input logic [NUM_CELLS-1:0][CELL_IN_W-1:0] v);
        i_lct_matrix_model.drive(v);
        repeat (4) @(posedge pclk);
    endtask : put

    // outputs of the flop cells as {cell4, cell3, cell1, cell0}
    task automatic fchk(input logic [3:0] e);
        chk({28'h0, matrix_out[4], matrix_out[3], matrix_out[1], matrix_out[0]}, {28'h0, e});
    endtask : fchk

    // main sequence
    initial
    begin
        apb_req = '0;
        presetn = 1'b0;
        miscompares = 0;
        check_count = 0;
        mv = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, OFF_PAT, 32'h0);
        chk(rd, 32'h0001_0000);
        xfer(1'b0, 8'h1c, 32'h0);
        chk({31'h0, er}, 32'h1);
        // reserved upper half must read back as zero
        xfer(1'b1, OFF_LUT3_HI, {16'hffff, t3[5], t3[4]});
        xfer(1'b0, OFF_LUT3_HI, 32'h0);
        chk(rd, {16'h0, t3[5], t3[4]});
        xfer(1'b1, OFF_LUT3_LO, {t3[3], t3[2], t3[1], t3[0]});
        for (int p = 0; p < 8; p++)
        begin
            for (int c = 3; c < 9; c++)
                mv[c] = p[2:0];
            put(mv);
            for (int c = 3; c < 9; c++)
                chk({31'h0, matrix_out[c]}, {31'h0, t3[c-3][p]});
        end
        // each gate in turn, rotated so every field holds a different one
        for (int g = 0; g < 6; g++)
        begin
            xfer(1'b1, OFF_LUT2, {16'h0, gates[(g+3)%6], gates[(g+2)%6], gates[(g+1)%6], gates[g]});
            for (int p = 0; p < 4; p++)
            begin
                for (int c = 0; c < 10; c++)
                    mv[c] = {1'b0, p[1:0]};
                put(mv);
                chk({28'h0, matrix_out[9], matrix_out[2], matrix_out[1], matrix_out[0]},
                    {28'h0, gates[(g+3)%6][p], gates[(g+2)%6][p], gates[(g+1)%6][p], gates[g][p]});
            end
        end
        // flops: cell0 edge, cell1 latch, cell3 delayed, cell4 preset type
        mv = '0;
        mv[3] = 3'b100;
        mv[4] = 3'b100;
        put(mv);
        xfer(1'b1, OFF_FLOP, 32'h0002_0000);
        xfer(1'b1, OFF_PAT, {12'h0, 4'h4, 11'h0, pat});
        xfer(1'b1, OFF_MODE, 32'h0001_221b);
        put(mv);
        fchk(4'b0000);
        chk({31'h0, matrix_out[9]}, {31'h0, pat[0]});
        mv[0] = 3'b010;
        mv[1] = 3'b010;
        mv[3] = 3'b110;
        mv[4] = 3'b110;
        put(mv);
        fchk(4'b0010);
        for (int c = 0; c < 5; c++)
            mv[c][0] = 1'b1;
        put(mv);
        fchk(4'b1011);
        for (int c = 0; c < 5; c++)
            mv[c][1] = 1'b0;
        put(mv);
        fchk(4'b1011);
        for (int c = 0; c < 5; c++)
            mv[c][0] = 1'b0;
        put(mv);
        fchk(4'b1101);
        for (int c = 0; c < 5; c++)
            mv[c][0] = 1'b1;
        put(mv);
        fchk(4'b0100);
        for (int c = 0; c < 5; c++)
            mv[c][0] = 1'b0;
        mv[4][2] = 1'b0;
        put(mv);
        fchk(4'b1000);
        // plain edge mode on cell3, preset still holding cell4
        xfer(1'b1, OFF_MODE, 32'h0000_221b);
        mv[3][1] = 1'b1;
        put(mv);
        for (int c = 0; c < 5; c++)
            mv[c][0] = 1'b1;
        put(mv);
        fchk(4'b1100);
        // pattern: release clear, then seven clock rises wrap past the end
        mv[9] = 3'b010;
        put(mv);
        for (int k = 1; k < 8; k++)
        begin
            mv[9][0] = 1'b1;
            put(mv);
            chk({31'h0, matrix_out[9]}, {31'h0, pat[k%5]});
            mv[9][0] = 1'b0;
            put(mv);
        end
        mv[9][1] = 1'b0;
        put(mv);
        chk({31'h0, matrix_out[9]}, {31'h0, pat[0]});
        // all back to lut mode: cell3 shows its truth bit
        xfer(1'b1, OFF_MODE, 32'h0);
        put(mv);
        chk({31'h0, matrix_out[3]}, {31'h0, t3[0][7]});
        test_done();
    end
endmodule : lct_cells_tb

// >>> sim/lct_matrix_model.sv
// routing matrix stand-in that drives the cell inputs as plain levels
`timescale 1ns/1ps
module lct_matrix_model (
    input  wire logic                                    pclk,
    output logic [lct_pkg::NUM_CELLS-1:0][lct_pkg::CELL_IN_W-1:0] matrix_in
);
    import lct_pkg::*;

    // levels start low so no cell sees a clock edge at power-up
    initial matrix_in = '0;

    // new levels land just after a rising edge and stand until the next call
    task automatic drive(input logic [NUM_CELLS-1:0][CELL_IN_W-1:0] v);
        @(posedge pclk);
        matrix_in <= v;
    endtask : drive
endmodule : lct_matrix_model

// >>> src/lct_cell.sv
// one combination cell: lut or flop/latch, with its input synchroniser
`timescale 1ns/1ps
module lct_cell #(
    parameter int unsigned N_IN      = 2,
    parameter bit          HAS_SR    = 1'b0,
    parameter bit          HAS_DELAY = 1'b0
)(
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic [lct_pkg::CELL_IN_W-1:0]  cell_in,
    input  wire logic [lct_pkg::LUT3_W-1:0]     truth,
    input  wire logic                           alt_mode,
    input  wire logic                           latch_mode,
    input  wire logic                           delay_mode,
    input  wire logic                           preset_sel,
    input  wire logic                           init_level,
    output logic [lct_pkg::CELL_IN_W-1:0]       cell_sync,
    output logic                                cell_out
);
    import lct_pkg::*;

    // whole cell state
    typedef struct packed {
        logic [CELL_IN_W-1:0] meta;
        logic [CELL_IN_W-1:0] sync;
        logic                 clk_prev;
        logic                 held;
        logic                 pend;
        logic                 out;
    } lct_cell_st_t;

    lct_cell_st_t q;
    lct_cell_st_t d;
    logic [CELL_IN_W-1:0] idx;      // lut index
    logic                 clk_s;    // cell clock after sync
    logic                 rise;
    logic                 fall;
    logic                 sr_act;   // shared set/reset asserted

    // two-input cells ignore the third input
    assign idx    = (N_IN == 2) ? {1'b0, q.sync[IN_DATA:IN_CLK]} : q.sync;
    assign clk_s  = q.sync[IN_CLK];
    assign rise   = clk_s & ~q.clk_prev;
    assign fall   = ~clk_s & q.clk_prev;
    assign sr_act = HAS_SR && !q.sync[IN_SR];

    // next state; edges come from the second sync stage only
    always_comb
    begin
        d = q;
        d.meta = cell_in;
        d.sync = q.meta;
        d.clk_prev = clk_s;
        if (!alt_mode)
        begin
            d.held = init_level;
            d.pend = init_level;
        end
        else if (sr_act)
        begin
            d.held = preset_sel;
            d.pend = preset_sel;
        end
        else if (latch_mode && N_IN == 2)
        begin
            if (!clk_s)
                d.held = q.sync[IN_DATA];
        end
        else if (rise)
        begin
            if (HAS_DELAY && delay_mode)
                d.pend = q.sync[IN_DATA];
            else
                d.held = q.sync[IN_DATA];
        end
        else if (fall && HAS_DELAY && delay_mode)
        begin
            d.held = q.pend;
        end
        // output back to the matrix, always from a flop
        d.out = alt_mode ? d.held : truth[idx];
    end

    // single state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= d;
    end

    assign cell_sync = q.sync;
    assign cell_out  = q.out;

    chk_lut_index: assert property (@(posedge pclk) disable iff (!presetn)
        !alt_mode |=> cell_out == $past(truth[idx]))
        else $error("lut output does not match truth bit");

    chk_gate_and: assert property (@(posedge pclk) disable iff (!presetn)
        (N_IN == 2 && !alt_mode && truth[LUT2_W-1:0] == GATE_AND)
        |=> cell_out == $past(q.sync[IN_CLK] & q.sync[IN_DATA]))
        else $error("and truth field not giving and");

    chk_edge_hold: assert property (@(posedge pclk) disable iff (!presetn)
        alt_mode ##1 (alt_mode && !latch_mode && !sr_act && !rise && !fall) ##1 alt_mode |-> $stable(cell_out))
        else $error("flop output moved without clock edge");

    chk_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (alt_mode && latch_mode && N_IN == 2 && clk_s && q.clk_prev) |=> cell_out == $past(cell_out))
        else $error("latch changed while clock high");

    chk_delay_late: assert property (@(posedge pclk) disable iff (!presetn)
        (HAS_DELAY && alt_mode && delay_mode && rise && !sr_act) |=> $stable(cell_out))
        else $error("delayed flop changed on rising edge");

    chk_sr_force: assert property (@(posedge pclk) disable iff (!presetn)
        (alt_mode && sr_act) |=> cell_out == $past(preset_sel))
        else $error("set or reset did not force output");

    chk_init_level: assert property (@(posedge pclk) disable iff (!presetn)
        (!alt_mode ##1 alt_mode && !sr_act && !rise && !fall && !latch_mode) |=> cell_out == $past(init_level, 2))
        else $error("flop did not start from initial level");

endmodule : lct_cell

// >>> src/lct_cells.sv
// combination cell array with apb configuration and the pattern sequencer
// How it works
// - two-input lut picks truth bit by inputs
// - lut2 fields at bits 1152 to 1163
// - pattern cell lut uses bits 1164-1167
// - truth fields give the standard gates
// - three-input lut picks bit, in2 most significant
// - six lut3 fields from bit 1184 upward
// - two-input flop: first clock, second data
// - edge flop loads data on rising edge
// - latch follows data while clock low
// - three-input flop: clock, data, shared set/reset
// - first set/reset flop normal when bit clear
// - bit set: capture rising, show falling
// - pattern of two to sixteen bits repeats
// - function chosen by stored configuration bits
// - three lut2, six lut3, one pattern cell
// - pattern cell: first clock, second clear
`timescale 1ns/1ps
module lct_cells (
    input  wire logic                                              pclk,
    input  wire logic                                              presetn,
    input  wire lct_pkg::lct_apb_req_t                             apb_req,
    output lct_pkg::lct_apb_rsp_t                                  apb_rsp,
    input  wire logic [lct_pkg::NUM_CELLS-1:0][lct_pkg::CELL_IN_W-1:0] matrix_in,
    output logic [lct_pkg::NUM_CELLS-1:0]                          matrix_out
);
    import lct_pkg::*;

    // whole top state: configuration image, bus answer, sequencer
    typedef struct packed {
        logic [31:0]          lut2;
        logic [31:0]          lut3_lo;
        logic [31:0]          lut3_hi;
        logic [31:0]          mode;
        logic [31:0]          flop;
        logic [31:0]          pat;
        // bus answer
        logic [31:0]          prdata;
        logic                 slverr;
        // sequencer state
        logic [PAT_IDX_W-1:0] pat_idx;
        logic                 pat_clk_prev;
        logic                 pat_out;
    } lct_top_st_t;

    lct_top_st_t q;
    lct_top_st_t d;

    logic [NUM_CELLS-1:0]                cell_out;    // raw cell outputs
    logic [NUM_CELLS-1:0][CELL_IN_W-1:0] cell_sync;   // synced inputs
    logic [NUM_LUT3FF*LUT3_W-1:0]        lut3_all;    // six lut3 fields

    // bus and sequencer helpers
    logic                                setup;
    logic                                wr_acc;
    logic                                pat_alt;
    logic                                pat_rise;
    logic                                pat_clear_n;
    logic [PAT_IDX_W-1:0]                pat_last;
    logic [31:0]                         strb_mask;

    // bus phases; no wait states so every access ends at once
    assign setup  = apb_req.psel && !apb_req.penable;
    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
    // one byte lane per strobe bit
    assign strb_mask = {{8{apb_req.pstrb[3]}}, {8{apb_req.pstrb[2]}},
                        {8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};

    // lut3 image in nvm order, split over two words
    assign lut3_all = {q.lut3_hi[NVM_LUT3_BASE + NUM_LUT3FF*LUT3_W - NVM_LUT3_SPLIT - 1:0],
                       q.lut3_lo};

    // sequencer inputs: first is clock, second is active-low clear
    assign pat_alt     = q.mode[MODE_ALT_LSB + PAT_CELL];
    assign pat_clear_n = cell_sync[PAT_CELL][IN_DATA];
    assign pat_rise    = cell_sync[PAT_CELL][IN_CLK] && !q.pat_clk_prev;
    // four length bits cap it at sixteen
    // a zero length field would stall the pattern, so clamp to two bits
    assign pat_last = (q.pat[PAT_LEN_LSB +: PAT_IDX_W] < PAT_MIN_LAST) ?
                      PAT_MIN_LAST : q.pat[PAT_LEN_LSB +: PAT_IDX_W];

    // merge a write under byte strobes and the writable mask
    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [31:0] smask,
        input logic [31:0] wmask
    );
        logic [31:0] en;
        en = smask & wmask;
        merge = (old_v & ~en) | (new_v & en);
    endfunction : merge

    // next state for registers, read answer and sequencer
    always_comb
    begin
        // all state holds unless moved below
        d = q;
        // writes take effect in the access phase
        // misaligned offsets miss every item
        if (wr_acc)
        begin
            unique case (apb_req.paddr)
                OFF_LUT2:    d.lut2    = merge(q.lut2, apb_req.pwdata, strb_mask, MASK_LUT2);
                OFF_LUT3_LO: d.lut3_lo = merge(q.lut3_lo, apb_req.pwdata, strb_mask, MASK_LUT3_LO);
                OFF_LUT3_HI: d.lut3_hi = merge(q.lut3_hi, apb_req.pwdata, strb_mask, MASK_LUT3_HI);
                OFF_MODE:    d.mode    = merge(q.mode, apb_req.pwdata, strb_mask, MASK_MODE);
                OFF_FLOP:    d.flop    = merge(q.flop, apb_req.pwdata, strb_mask, MASK_FLOP);
                OFF_PAT:     d.pat     = merge(q.pat, apb_req.pwdata, strb_mask, MASK_PAT);
                default:     ;   // status is read only, others unmapped
            endcase
        end

        // read data is prepared in setup so it comes from a flop
        // error flag refreshed on every setup
        if (setup)
        begin
            d.slverr = 1'b0;
            unique case (apb_req.paddr)
                OFF_LUT2:    d.prdata = q.lut2;
                OFF_LUT3_LO: d.prdata = q.lut3_lo;
                OFF_LUT3_HI: d.prdata = q.lut3_hi;
                OFF_MODE:    d.prdata = q.mode;
                OFF_FLOP:    d.prdata = q.flop;
                OFF_PAT:     d.prdata = q.pat;
                OFF_STAT:    d.prdata = 32'(matrix_out) | (32'(q.pat_idx) << STAT_IDX_LSB);
                default:
                begin
                    d.prdata = 32'h0000_0000;
                    d.slverr = 1'b1;   // unmapped address
                end
            endcase
        end

        // sequencer advances one bit per rising pattern clock
        // lut mode or low clear parks it on bit 0
        d.pat_clk_prev = cell_sync[PAT_CELL][IN_CLK];
        if (!pat_alt || !pat_clear_n)
            d.pat_idx = '0;
        else if (pat_rise)
        begin
            if (q.pat_idx >= pat_last)
                d.pat_idx = '0;
            else
                d.pat_idx = q.pat_idx + 1'b1;
        end
        d.pat_out = q.pat[PAT_BITS_LSB + d.pat_idx];
    end

    // config words load power-up values
    // single state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q         <= '0;
            q.lut2    <= RST_CFG;
            q.lut3_lo <= RST_CFG;
            q.lut3_hi <= RST_CFG;
            q.mode    <= RST_CFG;
            q.flop    <= RST_CFG;
            q.pat     <= RST_PAT;
        end
        else
        begin
            q <= d;
        end
    end

    // the ten cells, each a parameterised instance
    for (genvar i = 0; i < NUM_CELLS; i++)
    begin : g_cell
        localparam bit IS_LUT3 = (i >= SRFF_FIRST) && (i < SRFF_FIRST + NUM_LUT3FF);
        localparam bit IS_PAT  = (i == PAT_CELL);
        logic [LUT3_W-1:0] truth;   // truth field of this cell
        logic              alt;
        logic              latch;
        logic              pset;
        logic              init;
        // field and options by cell kind
        if (IS_LUT3)
        begin : g_l3
            assign truth = lut3_all[(i-SRFF_FIRST)*LUT3_W +: LUT3_W];
            assign pset  = q.flop[FLOP_SET_LSB + i - SRFF_FIRST];
            assign latch = 1'b0;
        end
        else if (IS_PAT)
        begin : g_pl
            assign truth = {{(LUT3_W-LUT2_W){1'b0}}, q.lut2[PATLUT_LSB +: LUT2_W]};
            assign pset  = 1'b0;
            assign latch = 1'b0;
        end
        else
        begin : g_l2
            assign truth = {{(LUT3_W-LUT2_W){1'b0}}, q.lut2[i*LUT2_W +: LUT2_W]};
            assign pset  = 1'b0;
            assign latch = q.mode[MODE_LATCH_LSB + i];
        end
        // the pattern cell's own flop is unused; the sequencer replaces it
        assign alt  = IS_PAT ? 1'b0 : q.mode[MODE_ALT_LSB + i];
        assign init = IS_PAT ? 1'b0 : q.flop[FLOP_INIT_LSB + i];

        // only the first set/reset cell delays
        lct_cell #(
            .N_IN      (IS_LUT3 ? 3 : 2),
            .HAS_SR    (IS_LUT3),
            .HAS_DELAY (i == SRFF_FIRST)
        ) u_cell (
            .pclk       (pclk),
            .presetn    (presetn),
            .cell_in    (matrix_in[i]),
            .truth      (truth),
            .alt_mode   (alt),
            .latch_mode (latch),
            .delay_mode (q.mode[MODE_DELAY_POS]),
            .preset_sel (pset),
            .init_level (init),
            .cell_sync  (cell_sync[i]),
            .cell_out   (cell_out[i])
        );
    end

    // outputs back to the matrix, sequencer muxed onto its cell
    always_comb
    begin
        // cell 9 lut output unused while sequencing
        matrix_out = cell_out;
        if (pat_alt)
            matrix_out[PAT_CELL] = q.pat_out;
    end

    // bus answer; pready is combinational, data from flops
    assign apb_rsp.prdata  = q.prdata;
    assign apb_rsp.pready  = apb_req.psel && apb_req.penable;
    // error shows only in the access phase
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && q.slverr;

    // placement, sequencer and bus checks
    chk_lut2_field: assert property (@(posedge pclk) disable iff (!presetn)
        g_cell[1].truth[LUT2_W-1:0] == q.lut2[(NVM_LUT2_BASE + LUT2_W - NVM_LUT2_BASE) +: LUT2_W])
        else $error("second lut2 field misplaced");

    chk_lut3_field: assert property (@(posedge pclk) disable iff (!presetn)
        g_cell[SRFF_FIRST + NUM_LUT3FF - 1].truth == q.lut3_hi[LUT3_W +: LUT3_W])
        else $error("sixth lut3 field misplaced");

    chk_pat_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (pat_alt && !pat_clear_n) |=> q.pat_idx == '0 && matrix_out[PAT_CELL] == q.pat[PAT_BITS_LSB])
        else $error("clear did not return to first pattern bit");

    chk_pat_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        (pat_alt && pat_clear_n && pat_rise && q.pat_idx == pat_last) |=> q.pat_idx == '0)
        else $error("pattern did not wrap after last bit");

    chk_pat_step: assert property (@(posedge pclk) disable iff (!presetn)
        (pat_alt && pat_clear_n && !pat_rise) ##1 pat_alt |-> $stable(q.pat_idx))
        else $error("pattern moved without clock edge");

    chk_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && apb_req.paddr > OFF_STAT) |=> apb_rsp.pslverr == (apb_req.psel && apb_req.penable))
        else $error("unmapped access without error");

    chk_mode_steer: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && apb_req.paddr == OFF_MODE && apb_req.pstrb[0] && !apb_req.pwdata[0])
        |=> g_cell[0].alt == 1'b0)
        else $error("mode write did not select lut function");

    cov_pat_wrap: cover property (@(posedge pclk) disable iff (!presetn)
        pat_alt && pat_rise && q.pat_idx == pat_last);

    cov_sr_flop: cover property (@(posedge pclk) disable iff (!presetn)
        q.mode[MODE_ALT_LSB + SRFF_FIRST] && !cell_sync[SRFF_FIRST][IN_SR]);

    cov_delay_mode: cover property (@(posedge pclk) disable iff (!presetn)
        q.mode[MODE_DELAY_POS] && q.mode[MODE_ALT_LSB + SRFF_FIRST] && $changed(cell_out[SRFF_FIRST]));

    cov_pat_clear: cover property (@(posedge pclk) disable iff (!presetn)
        pat_alt && !pat_clear_n && q.pat_idx != '0);

    // pattern cell lut sits above the lut2 fields
    chk_patlut_field: assert property (@(posedge pclk) disable iff (!presetn)
        g_cell[PAT_CELL].truth[LUT2_W-1:0] == q.lut2[PATLUT_LSB +: LUT2_W])
        else $error("pattern cell lut field misplaced");

    // first lut3 field at the bottom of the low word
    chk_lut3_first: assert property (@(posedge pclk) disable iff (!presetn)
        g_cell[SRFF_FIRST].truth == q.lut3_lo[LUT3_W-1:0])
        else $error("first lut3 field misplaced");

    // a read returns the word seen at its setup edge
    chk_read_word: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !apb_req.pwrite && apb_req.paddr == OFF_PAT) |=> apb_rsp.prdata == $past(q.pat))
        else $error("read data not from addressed word");

    // latch holding while its data moves
    cov_latch_hold: cover property (@(posedge pclk) disable iff (!presetn)
        q.mode[MODE_LATCH_LSB + 1] && cell_sync[1][IN_CLK] && $changed(cell_sync[1][IN_DATA]));

endmodule : lct_cells

// >>> src/lct_pkg.sv
// shared constants and carrier types for the combination cell block
package lct_pkg;

    // cell counts and input roles
    localparam int unsigned NUM_LUT2FF = 3;
    localparam int unsigned NUM_LUT3FF = 6;
    localparam int unsigned NUM_CELLS  = 10;
    localparam int unsigned SRFF_FIRST = 3;
    localparam int unsigned PAT_CELL   = 9;
    localparam int unsigned CELL_IN_W  = 3;
    localparam int unsigned IN_CLK     = 0;
    localparam int unsigned IN_DATA    = 1;
    localparam int unsigned IN_SR      = 2;
    localparam int unsigned LUT2_W     = 4;
    localparam int unsigned LUT3_W     = 8;

    // pattern sequencer sizes
    localparam int unsigned PAT_MAX   = 16;
    localparam int unsigned PAT_IDX_W = 4;
    localparam logic [PAT_IDX_W-1:0] PAT_MIN_LAST = 4'h1;

    // nonvolatile bit numbers, registers hold them from these bases
    localparam int unsigned NVM_LUT2_BASE   = 1152;
    localparam int unsigned NVM_PATLUT_BASE = 1164;
    localparam int unsigned NVM_LUT3_BASE   = 1184;
    localparam int unsigned NVM_LUT3_SPLIT  = 1216;
    localparam int unsigned NVM_DELAY_BIT   = 1237;
    localparam int unsigned PATLUT_LSB = NVM_PATLUT_BASE - NVM_LUT2_BASE;

    // apb map, byte addresses
    localparam int unsigned ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_LUT2    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_LUT3_LO = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_LUT3_HI = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_MODE    = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_FLOP    = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_PAT     = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STAT    = 8'h18;

    // field positions
    localparam int unsigned MODE_ALT_LSB   = 0;
    localparam int unsigned MODE_LATCH_LSB = 12;
    localparam int unsigned MODE_DELAY_POS = 16;
    localparam int unsigned FLOP_INIT_LSB  = 0;
    localparam int unsigned FLOP_SET_LSB   = 16;
    localparam int unsigned PAT_BITS_LSB   = 0;
    localparam int unsigned PAT_LEN_LSB    = 16;
    localparam int unsigned STAT_IDX_LSB   = 16;

    // writable bits, reserved bits read as zero
    localparam logic [31:0] MASK_LUT2    = 32'h0000_ffff;
    localparam logic [31:0] MASK_LUT3_LO = 32'hffff_ffff;
    localparam logic [31:0] MASK_LUT3_HI = 32'h0000_ffff;
    localparam logic [31:0] MASK_MODE    = 32'h0001_73ff;
    localparam logic [31:0] MASK_FLOP    = 32'h003f_01ff;
    localparam logic [31:0] MASK_PAT     = 32'h000f_ffff;

    // power-up contents: all cells plain lut, pattern of two bits
    localparam logic [31:0] RST_CFG = 32'h0000_0000;
    localparam logic [31:0] RST_PAT = 32'h0001_0000;

    // truth fields for the standard two-input gates
    localparam logic [LUT2_W-1:0] GATE_AND  = 4'h8;
    localparam logic [LUT2_W-1:0] GATE_NAND = 4'h7;
    localparam logic [LUT2_W-1:0] GATE_OR   = 4'he;
    localparam logic [LUT2_W-1:0] GATE_NOR  = 4'h1;
    localparam logic [LUT2_W-1:0] GATE_XOR  = 4'h6;
    localparam logic [LUT2_W-1:0] GATE_XNOR = 4'h9;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
        logic [3:0]        pstrb;
    } lct_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } lct_apb_rsp_t;

endpackage : lct_pkg
